// >>> logic/tmc_timer_pair.sv
// tmc_timer_pair: control registers and counting logic of the lower
// and upper 8-bit timer/counters, cascadable into one 16-bit counter.
// assumes clk is the high-frequency clock and all inputs are synchronous.
// How it works
// - lower counter has one control register, an 8-bit period and pulse width
// - after reset period and pulse width read 0xff, control reads 0x00
// - clock code picks high clock taps, low clock, or the external pin
// - prescaler option or slow mode turn code 000 into low clock / 8
// - start low stops and clears the count; start high counts
// - mode 000 timer, 001 divider, 010 PWM, 011 cascade, 1xx reserved
// - in cascade lower clock select drives; upper start and ff govern
// - upper counter has its own control, period and pulse width
// - upper modes 100 timer16, 101 warm-up, 110 PWM16, 111 PPG
// - upper mode 1xx counts lower overflows, ignoring its clock select
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module tmc_timer_pair (
   input wire logic clk, // high-frequency clock, 20 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic [7:0] regAddr, // register address
   input wire logic [7:0] regWrData, // register write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   output logic [7:0] regRdData, // read data, cycle after strobe
   input wire logic lowClkTick, // low clock enable pulse
   input wire logic prescalerOption, // prescaler option bit
   input wire logic slowMode, // slow or sleep mode active
   input wire logic loPin, // lower counter external pin
   input wire logic hiPin, // upper counter external pin
   output logic loOutFf, // lower timer output flip-flop
   output logic hiOutFf, // upper timer output flip-flop
   output logic loIrq, // lower interrupt request pulse
   output logic hiIrq // upper interrupt request pulse
);
   tmc_pkg::tmc_ctrl_t loCtrl_ff;
   tmc_pkg::tmc_ctrl_t hiCtrl_ff;
   logic [7:0] loPeriod_ff;
   logic [7:0] loPulse_ff;
   logic [7:0] hiPeriod_ff;
   logic [7:0] hiPulse_ff;
   logic [7:0] loCnt_ff;
   logic [7:0] hiCnt_ff;
   logic loPinPrev_ff;
   logic hiPinPrev_ff;
   tmc_pkg::tmc_tick_t ticks;
   logic cascade;
   logic loRun;
   logic loFfInit;
   logic loTick;
   logic hiTick;
   logic loCarry;
   logic clr16;
   logic match16Period;
   logic match16Pulse;
   logic [15:0] cnt16;

   // selects the count enable for one clock code
   function automatic logic clkPick(input logic [2:0] code,
                                    input tmc_pkg::tmc_tick_t tk,
                                    input logic altSrc,
                                    input logic slow,
                                    input logic pinRise);
      logic hit;
      hit = 1'b0;
      case (code)
         tmc_pkg::CK_DIV11: hit = altSrc ? tk.lowDiv3 : tk.div11;
         tmc_pkg::CK_DIV7: hit = slow ? 1'b0 : tk.div7;
         tmc_pkg::CK_DIV5: hit = slow ? 1'b0 : tk.div5;
         tmc_pkg::CK_DIV3: hit = slow ? 1'b0 : tk.div3;
         tmc_pkg::CK_LOW: hit = tk.low;
         tmc_pkg::CK_DIV1: hit = slow ? 1'b0 : tk.div1;
         tmc_pkg::CK_HIGH: hit = 1'b1;
         tmc_pkg::CK_PIN: hit = pinRise;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   tmc_prescaler uPre (
      .clk(clk),
      .rst_n(rst_n),
      .lowClkTick(lowClkTick),
      .ticks(ticks)
   );

   // register writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loPeriod_ff <= tmc_pkg::RST_PERIOD;
         loPulse_ff <= tmc_pkg::RST_PULSE;
         loCtrl_ff <= tmc_pkg::RST_CTRL;
         hiPeriod_ff <= tmc_pkg::RST_PERIOD;
         hiPulse_ff <= tmc_pkg::RST_PULSE;
         hiCtrl_ff <= tmc_pkg::RST_CTRL;
      end else if (regWr) begin
         case (regAddr)
            tmc_pkg::OFF_LO_PERIOD: loPeriod_ff <= regWrData;
            tmc_pkg::OFF_LO_PULSE: loPulse_ff <= regWrData;
            tmc_pkg::OFF_LO_CTRL: loCtrl_ff <= regWrData;
            tmc_pkg::OFF_HI_PERIOD: hiPeriod_ff <= regWrData;
            tmc_pkg::OFF_HI_PULSE: hiPulse_ff <= regWrData;
            tmc_pkg::OFF_HI_CTRL: hiCtrl_ff <= regWrData;
            default: ;
         endcase
      end
   end

   // register reads, data stand one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            tmc_pkg::OFF_LO_PERIOD: regRdData <= loPeriod_ff;
            tmc_pkg::OFF_LO_PULSE: regRdData <= loPulse_ff;
            tmc_pkg::OFF_LO_CTRL: regRdData <= loCtrl_ff;
            tmc_pkg::OFF_HI_PERIOD: regRdData <= hiPeriod_ff;
            tmc_pkg::OFF_HI_PULSE: regRdData <= hiPulse_ff;
            tmc_pkg::OFF_HI_CTRL: regRdData <= hiCtrl_ff;
            tmc_pkg::OFF_LO_COUNT: regRdData <= loCnt_ff;
            tmc_pkg::OFF_HI_COUNT: regRdData <= hiCnt_ff;
            default: regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   // pin history for rising-edge count enables
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loPinPrev_ff <= 1'b0;
         hiPinPrev_ff <= 1'b0;
      end else begin
         loPinPrev_ff <= loPin;
         hiPinPrev_ff <= hiPin;
      end
   end

   // effective controls and count enables
   always_comb begin
      cascade = (loCtrl_ff.mode == tmc_pkg::MODE_CASCADE);
      loRun = cascade ? hiCtrl_ff.start : loCtrl_ff.start;
      loFfInit = cascade ? hiCtrl_ff.outFf : loCtrl_ff.outFf;
      loTick = clkPick(loCtrl_ff.clkSel, ticks,
                       prescalerOption | slowMode, slowMode,
                       loPin & ~loPinPrev_ff);
      cnt16 = {hiCnt_ff, loCnt_ff};
      match16Period = (cnt16 == {hiPeriod_ff, loPeriod_ff});
      match16Pulse = (cnt16 == {hiPulse_ff, loPulse_ff});
      clr16 = 1'b0;
      if (cascade && loRun && loTick) begin
         case (hiCtrl_ff.mode)
            tmc_pkg::MODE_TIMER16: clr16 = match16Period;
            tmc_pkg::MODE_WARMUP: clr16 = match16Period;
            tmc_pkg::MODE_PPG16: clr16 = match16Period;
            default: clr16 = 1'b0;
         endcase
      end
      loCarry = cascade && loRun && loTick && !clr16
                && (loCnt_ff == tmc_pkg::CNT_MAX);
      if (hiCtrl_ff.mode[2]) begin
         hiTick = loCarry;
      end else begin
         hiTick = clkPick(hiCtrl_ff.clkSel, ticks,
                          prescalerOption | slowMode, slowMode,
                          hiPin & ~hiPinPrev_ff);
      end
   end

   // lower counter, its output flip-flop and its interrupt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loCnt_ff <= 8'h00;
         loOutFf <= 1'b0;
         loIrq <= 1'b0;
      end else begin
         loIrq <= 1'b0;
         if (!loRun) begin
            loCnt_ff <= 8'h00;
            loOutFf <= loFfInit;
         end else if (loTick) begin
            case (loCtrl_ff.mode)
               tmc_pkg::MODE_TIMER: begin
                  if (loCnt_ff == loPeriod_ff) begin
                     loCnt_ff <= 8'h00;
                     loIrq <= 1'b1;
                  end else begin
                     loCnt_ff <= loCnt_ff + 1'b1;
                  end
               end
               tmc_pkg::MODE_PDO: begin
                  if (loCnt_ff == loPeriod_ff) begin
                     loCnt_ff <= 8'h00;
                     loOutFf <= ~loOutFf;
                     loIrq <= 1'b1;
                  end else begin
                     loCnt_ff <= loCnt_ff + 1'b1;
                  end
               end
               tmc_pkg::MODE_PWM8: begin
                  loCnt_ff <= loCnt_ff + 1'b1;
                  if (loCnt_ff == tmc_pkg::CNT_MAX) begin
                     loOutFf <= loFfInit;
                     loIrq <= 1'b1;
                  end else if (loCnt_ff == loPulse_ff) begin
                     loOutFf <= ~loFfInit;
                  end
               end
               tmc_pkg::MODE_CASCADE: begin
                  loCnt_ff <= clr16 ? 8'h00 : loCnt_ff + 1'b1;
               end
               default: loCnt_ff <= loCnt_ff;
            endcase
         end
      end
   end

   // upper counter, alone or as the high byte of the cascade
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hiCnt_ff <= 8'h00;
         hiOutFf <= 1'b0;
         hiIrq <= 1'b0;
      end else begin
         hiIrq <= 1'b0;
         if (!hiCtrl_ff.start) begin
            hiCnt_ff <= 8'h00;
            hiOutFf <= hiCtrl_ff.outFf;
         end else begin
            case (hiCtrl_ff.mode)
               tmc_pkg::MODE_TIMER: begin
                  if (hiTick) begin
                     if (hiCnt_ff == hiPeriod_ff) begin
                        hiCnt_ff <= 8'h00;
                        hiIrq <= 1'b1;
                     end else begin
                        hiCnt_ff <= hiCnt_ff + 1'b1;
                     end
                  end
               end
               tmc_pkg::MODE_PDO: begin
                  if (hiTick) begin
                     if (hiCnt_ff == hiPeriod_ff) begin
                        hiCnt_ff <= 8'h00;
                        hiOutFf <= ~hiOutFf;
                        hiIrq <= 1'b1;
                     end else begin
                        hiCnt_ff <= hiCnt_ff + 1'b1;
                     end
                  end
               end
               tmc_pkg::MODE_PWM8: begin
                  if (hiTick) begin
                     hiCnt_ff <= hiCnt_ff + 1'b1;
                     if (hiCnt_ff == tmc_pkg::CNT_MAX) begin
                        hiOutFf <= hiCtrl_ff.outFf;
                        hiIrq <= 1'b1;
                     end else if (hiCnt_ff == hiPulse_ff) begin
                        hiOutFf <= ~hiCtrl_ff.outFf;
                     end
                  end
               end
               tmc_pkg::MODE_TIMER16, tmc_pkg::MODE_WARMUP: begin
                  if (clr16) begin
                     hiCnt_ff <= 8'h00;
                     hiIrq <= 1'b1;
                  end else if (hiTick) begin
                     hiCnt_ff <= hiCnt_ff + 1'b1;
                  end
               end
               tmc_pkg::MODE_PWM16: begin
                  if (cascade && loTick) begin
                     if (cnt16 == 16'hffff) begin
                        hiOutFf <= hiCtrl_ff.outFf;
                        hiIrq <= 1'b1;
                     end else if (match16Pulse) begin
                        hiOutFf <= ~hiCtrl_ff.outFf;
                     end
                  end
                  if (hiTick) begin
                     hiCnt_ff <= hiCnt_ff + 1'b1;
                  end
               end
               tmc_pkg::MODE_PPG16: begin
                  if (clr16) begin
                     hiCnt_ff <= 8'h00;
                     hiOutFf <= hiCtrl_ff.outFf;
                     hiIrq <= 1'b1;
                  end else begin
                     if (cascade && loTick && match16Pulse) begin
                        hiOutFf <= ~hiCtrl_ff.outFf;
                     end
                     if (hiTick) begin
                        hiCnt_ff <= hiCnt_ff + 1'b1;
                     end
                  end
               end
               default: hiCnt_ff <= hiCnt_ff;
            endcase
         end
      end
   end
endmodule

// >>> logic/tmc_pkg.sv
// tmc_pkg: register map, field layout, reset values and mode codes
// for the cascadable pair of 8-bit timer/counters.
// assumes an 8-bit register port clocked by the high-frequency clock.
package tmc_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;

   // register offsets
   localparam logic [7:0] OFF_LO_PERIOD = 8'h14;
   localparam logic [7:0] OFF_LO_PULSE = 8'h18;
   localparam logic [7:0] OFF_LO_CTRL = 8'h27;
   localparam logic [7:0] OFF_HI_CTRL = 8'h28;
   localparam logic [7:0] OFF_HI_PERIOD = 8'h15;
   localparam logic [7:0] OFF_HI_PULSE = 8'h19;
   localparam logic [7:0] OFF_LO_COUNT = 8'h2a;
   localparam logic [7:0] OFF_HI_COUNT = 8'h2b;

   // reset values and the counter maximum
   localparam logic [7:0] RST_PERIOD = 8'hff;
   localparam logic [7:0] RST_PULSE = 8'hff;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hff;

   // prescaler tap widths (high or low clock divided by 2^n)
   localparam int PRE_W = 11;
   localparam int LOW_DIV_W = 3;

   // control register layout: bit 7 ff, 6:4 clock, 3 start, 2:0 mode
   typedef struct packed {
      logic outFf;
      logic [2:0] clkSel;
      logic start;
      logic [2:0] mode;
   } tmc_ctrl_t;

   // operating mode codes
   localparam logic [2:0] MODE_TIMER = 3'h0;
   localparam logic [2:0] MODE_PDO = 3'h1;
   localparam logic [2:0] MODE_PWM8 = 3'h2;
   localparam logic [2:0] MODE_CASCADE = 3'h3;
   localparam logic [2:0] MODE_TIMER16 = 3'h4;
   localparam logic [2:0] MODE_WARMUP = 3'h5;
   localparam logic [2:0] MODE_PWM16 = 3'h6;
   localparam logic [2:0] MODE_PPG16 = 3'h7;

   // clock select codes
   localparam logic [2:0] CK_DIV11 = 3'h0;
   localparam logic [2:0] CK_DIV7 = 3'h1;
   localparam logic [2:0] CK_DIV5 = 3'h2;
   localparam logic [2:0] CK_DIV3 = 3'h3;
   localparam logic [2:0] CK_LOW = 3'h4;
   localparam logic [2:0] CK_DIV1 = 3'h5;
   localparam logic [2:0] CK_HIGH = 3'h6;
   localparam logic [2:0] CK_PIN = 3'h7;

   // one-cycle enables from the prescaler
   typedef struct packed {
      logic div11;
      logic div7;
      logic div5;
      logic div3;
      logic div1;
      logic low;
      logic lowDiv3;
   } tmc_tick_t;
endpackage

// >>> logic/tmc_prescaler.sv
// tmc_prescaler: divides the high clock and the low-clock tick into
// the one-cycle count enables used by the timer clock selectors.
// assumes lowClkTick is a one-cycle pulse per low-frequency period.
`timescale 1ns/1ns
module tmc_prescaler (
   input wire logic clk, // high-frequency clock
   input wire logic rst_n, // async reset, active low
   input wire logic lowClkTick, // one pulse per low clock period
   output tmc_pkg::tmc_tick_t ticks // divided count enables
);
   logic [tmc_pkg::PRE_W-1:0] preCnt_ff;
   logic [tmc_pkg::LOW_DIV_W-1:0] lowCnt_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preCnt_ff <= '0;
      end else begin
         preCnt_ff <= preCnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt_ff <= '0;
      end else if (lowClkTick) begin
         lowCnt_ff <= lowCnt_ff + 1'b1;
      end
   end

   // each tap fires once when its low bits are all ones
   always_comb begin
      ticks.div11 = &preCnt_ff[10:0];
      ticks.div7 = &preCnt_ff[6:0];
      ticks.div5 = &preCnt_ff[4:0];
      ticks.div3 = &preCnt_ff[2:0];
      ticks.div1 = preCnt_ff[0];
      ticks.low = lowClkTick;
      ticks.lowDiv3 = lowClkTick & (&lowCnt_ff);
   end
endmodule

// >>> sim/tmc_timer_pair_asserts.sv
// tmc_timer_pair_asserts: port-level checks of the lower period, control and count registers and the upper control register
// assumes it is bound to tmc_timer_pair and sees only its ports
`timescale 1ns/1ns
module tmc_timer_pair_asserts (
   input wire logic clk, // high-frequency clock
   input wire logic rst_n, // async reset, active low
   input wire logic [7:0] regAddr, // register address
   input wire logic [7:0] regWrData, // write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   input wire logic [7:0] regRdData, // read data
   input wire logic loOutFf, // lower output flip-flop
   input wire logic loIrq // lower interrupt pulse
);
   logic [7:0] period_ff, ctl_ff, hiCtl_ff, gap_ff;
   logic arm_ff;
   logic timerRun;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // shadow copies of what software wrote
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         period_ff <= 8'hff;
         ctl_ff <= 8'h00;
         hiCtl_ff <= 8'h00;
      end else if (regWr) begin
         case (regAddr)
            tmc_pkg::OFF_LO_PERIOD: period_ff <= regWrData;
            tmc_pkg::OFF_LO_CTRL: ctl_ff <= regWrData;
            tmc_pkg::OFF_HI_CTRL: hiCtl_ff <= regWrData;
            default: ;
         endcase
      end
   end
   // timer mode on the undivided clock, started
   assign timerRun = ctl_ff == 8'h68;
   // cycles since the last interrupt under an unchanged setup
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_ff <= 8'h00;
         arm_ff <= 1'b0;
      end else if (!timerRun || regWr) begin
         gap_ff <= 8'h00;
         arm_ff <= 1'b0;
      end else if (loIrq) begin
         gap_ff <= 8'h00;
         arm_ff <= 1'b1;
      end else begin
         gap_ff <= gap_ff + 8'h01;
      end
   end
   AST_RD_IDLE: assert property (
      !$past(regRd) |-> regRdData == 8'h00) else $error("read data not idle");
   AST_PERIOD_RB: assert property (
      regRd && regAddr == tmc_pkg::OFF_LO_PERIOD |=> regRdData == period_ff)
      else $error("period readback wrong");
   AST_CTRL_RB: assert property (
      regRd && regAddr == tmc_pkg::OFF_LO_CTRL |=> regRdData == ctl_ff)
      else $error("control readback wrong");
   AST_HICTRL_RB: assert property (
      regRd && regAddr == tmc_pkg::OFF_HI_CTRL |=> regRdData == hiCtl_ff)
      else $error("upper control readback wrong");
   AST_UNMAPPED: assert property (
      regRd && !(regAddr inside {8'h14, 8'h15, 8'h18, 8'h19, 8'h27, 8'h28,
      8'h2a, 8'h2b}) |=> regRdData == 8'h00) else $error("unmapped read");
   AST_STOP_NOIRQ: assert property (
      !ctl_ff[3] && !$past(ctl_ff[3]) && !$past(ctl_ff[3], 2) &&
      ctl_ff[2:0] != 3'h3 |-> !loIrq) else $error("irq while stopped");
   AST_STOP_FF: assert property (
      !ctl_ff[3] && $stable(ctl_ff) && ctl_ff[2:0] != 3'h3
      |-> loOutFf == ctl_ff[7]) else $error("stopped ff level wrong");
   AST_IRQ_GAP: assert property (
      loIrq && arm_ff |-> gap_ff == period_ff) else $error("irq spacing wrong");
   AST_CNT_STOP: assert property (
      regRd && regAddr == tmc_pkg::OFF_LO_COUNT && !ctl_ff[3] &&
      !$past(ctl_ff[3]) && ctl_ff[2:0] != 3'h3 |=> regRdData == 8'h00)
      else $error("count not cleared");
endmodule
bind tmc_timer_pair tmc_timer_pair_asserts i_chk (.clk(clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .loOutFf(loOutFf), .loIrq(loIrq));

// >>> sim/tmc_timer_pair_tb.sv
// tmc_timer_pair_tb: self-checking bench for the timer pair
// assumes a 20 MHz clock and a low clock tick every four cycles
`timescale 1ns/1ns
module tmc_timer_pair_tb;
   logic clk, rst_n, regWr, regRd, lowClkTick, prescalerOption;
   // lowClkTick, loPin and tickCnt have one driver: the tick process
   logic slowMode, loPin, hiPin, loOutFf, hiOutFf, loIrq, hiIrq;
   logic [7:0] regAddr, regWrData, regRdData, d, tickCnt;
   int err_total, checks_done;
   tmc_timer_pair i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .lowClkTick(lowClkTick),
      .prescalerOption(prescalerOption), .slowMode(slowMode),
      .loPin(loPin), .hiPin(hiPin), .loOutFf(loOutFf), .hiOutFf(hiOutFf),
      .loIrq(loIrq), .hiIrq(hiIrq));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // low clock tick every 4 cycles, pin rising edge every 8
   always @(posedge clk) begin
      if (!rst_n) begin
         tickCnt <= 8'h00;
         lowClkTick <= 1'b0;
         loPin <= 1'b0;
      end else begin
         tickCnt <= tickCnt + 8'h01;
         lowClkTick <= tickCnt[1:0] == 2'h3;
         loPin <= tickCnt[2];
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdData;
      @(posedge clk);
   endtask
   // cycles between two interrupt pulses of one counter
   task automatic gap(input logic hi, input logic [15:0] exp);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while ((hi ? hiIrq : loIrq) !== 1'b1 && n < 5000);
      end
      chk(n[15:0], exp);
      @(posedge clk);
   endtask
   task automatic run(input logic [2:0] ck, input logic [15:0] exp);
      wr(8'h27, {1'b0, ck, 4'h8});
      gap(1'b0, exp);
      wr(8'h27, {1'b0, ck, 4'h0});
      rd(8'h2a, d);
      chk({8'h00, d}, 16'h0000);
   endtask
   task automatic t_reset;
      logic [7:0] a [8];
      logic [7:0] e [8];
      a = '{8'h14, 8'h18, 8'h27, 8'h15, 8'h19, 8'h28, 8'h2a, 8'h30};
      e = '{8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rd(a[i], d);
         chk({8'h00, d}, {8'h00, e[i]});
      end
      $display("test reset done");
   endtask
   task automatic t_rw;
      logic [7:0] a [4];
      a = '{8'h14, 8'h18, 8'h15, 8'h19};
      for (int i = 0; i < 4; i++) wr(a[i], 8'h30 + 8'(i));
      for (int i = 0; i < 4; i++) begin
         rd(a[i], d);
         chk({8'h00, d}, 16'h0030 + 16'(i));
      end
      $display("test readback done");
   endtask
   task automatic t_ff;
      wr(8'h27, 8'h80);
      wr(8'h28, 8'h80);
      @(posedge clk);
      chk({15'h0000, loOutFf}, 16'h0001);
      chk({15'h0000, hiOutFf}, 16'h0001);
      wr(8'h27, 8'h00);
      wr(8'h28, 8'h00);
      @(posedge clk);
      chk({15'h0000, loOutFf}, 16'h0000);
      chk({15'h0000, hiOutFf}, 16'h0000);
      $display("test flip-flop done");
   endtask
   task automatic t_clk;
      logic [15:0] e [8];
      e = '{16'h1000, 16'h0100, 16'h0040, 16'h0010, 16'h0008, 16'h0004,
         16'h0002, 16'h0010};
      wr(8'h14, 8'h01);
      for (int c = 0; c < 8; c++) run(3'(c), e[c]);
      prescalerOption <= 1'b1;
      run(3'h0, 16'h0040);
      prescalerOption <= 1'b0;
      slowMode <= 1'b1;
      run(3'h0, 16'h0040);
      run(3'h6, 16'h0002);
      slowMode <= 1'b0;
      $display("test clock select done");
   endtask
   task automatic t_mode;
      wr(8'h27, 8'h6c);
      repeat (20) @(posedge clk);
      rd(8'h2a, d);
      chk({8'h00, d}, 16'h0000);
      wr(8'h27, 8'h64);
      // divider output toggles at every period match
      wr(8'h27, 8'h69);
      gap(1'b0, 16'h0002);
      d[0] = loOutFf;
      repeat (2) @(posedge clk);
      chk({15'h0000, loOutFf}, {15'h0000, ~d[0]});
      wr(8'h27, 8'h61);
      // pwm: low from the wrap, high once the count passes the pulse width
      wr(8'h27, 8'h6a);
      gap(1'b0, 16'h0100);
      chk({15'h0000, loOutFf}, 16'h0000);
      repeat (64) @(posedge clk);
      chk({15'h0000, loOutFf}, 16'h0001);
      wr(8'h27, 8'h62);
      $display("test modes done");
   endtask
   task automatic t_casc;
      wr(8'h14, 8'h03);
      wr(8'h15, 8'h01);
      wr(8'h27, 8'h63);
      wr(8'h28, 8'h0c);
      rd(8'h28, d);
      chk({8'h00, d}, 16'h000c);
      gap(1'b1, 16'h0104);
      wr(8'h28, 8'h04);
      wr(8'h27, 8'h00);
      $display("test cascade done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      {regWr, regRd, prescalerOption} = 3'h0;
      {slowMode, hiPin} = 2'h0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      err_total = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_rw;
      t_ff;
      t_clk;
      t_mode;
      t_casc;
      stop_test;
   end
   // tests need about 10000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      stop_test;
   end
endmodule
